// >>> design/lcc_pkg.sv
package lcc_pkg;
  // register map inside one channel window
  localparam logic [7:0] LCC_CHAN_STRIDE = 8'h20;
  localparam logic [4:0] LCC_OFS_CLOCK_MODE = 5'h07;
  localparam logic [4:0] LCC_OFS_LOOP_CTRL = 5'h08;
  localparam logic [4:0] LCC_OFS_PULSE_MASK_0 = 5'h09;
  localparam logic [4:0] LCC_OFS_PULSE_MASK_1 = 5'h0A;
  localparam logic [4:0] LCC_OFS_PULSE_MASK_2 = 5'h0B;
  localparam logic [4:0] LCC_OFS_LOS_DETECT = 5'h0C;
  localparam logic [4:0] LCC_OFS_LOS_RECOVERY = 5'h0D;
  localparam logic [4:0] LCC_OFS_LOOP_CODE = 5'h0E;
  localparam logic [4:0] LCC_OFS_LOS_CONFIG = 5'h14;
  localparam logic [4:0] LCC_OFS_STATUS = 5'h15;
  // reset values
  localparam logic [7:0] LCC_RST_CLOCK_MODE = 8'h08;
  localparam logic [7:0] LCC_RST_LOOP_CTRL = 8'h00;
  localparam logic [7:0] LCC_RST_PULSE_MASK_0 = 8'h73;
  localparam logic [7:0] LCC_RST_PULSE_MASK_1 = 8'h02;
  localparam logic [7:0] LCC_RST_PULSE_MASK_2 = 8'h00;
  localparam logic [7:0] LCC_RST_LOS_DETECT = 8'hC0;
  localparam logic [7:0] LCC_RST_LOS_RECOVERY = 8'h18;
  localparam logic [7:0] LCC_RST_LOOP_CODE = 8'h40;
  localparam logic [7:0] LCC_RST_LOS_CONFIG = 8'h00;
  // clock mode fields
  localparam int LCC_CM_RSRC_LSB = 4;
  localparam int LCC_CM_DCS = 3;
  localparam int LCC_CM_SCF = 2;
  localparam int LCC_CM_ELT = 1;
  localparam int LCC_CM_MAS = 0;
  // loop control fields
  localparam int LCC_LC_POS = 7;
  localparam int LCC_LC_EN = 6;
  localparam int LCC_LC_RL = 5;
  localparam int LCC_LC_LL = 4;
  localparam int LCC_LC_DLB = 3;
  localparam int LCC_LC_CLR = 2;
  localparam int LCC_LC_BS_LSB = 0;
  // pulse mask 2 control bits
  localparam int LCC_PM_RSVD = 7;
  localparam int LCC_PM_XLT = 6;
  localparam int LCC_PM_DISABLE_AUTO_TRISTATE = 5;
  localparam int LCC_PM_HC = 4;
  // extra los config register fields
  localparam int LCC_LS_COND_LSB = 0;
  localparam int LCC_LS_DIGI = 2;
  localparam int LCC_LS_AIS = 3;
  // receive clock source codes
  localparam logic [1:0] LCC_RS_PLL = 2'h0;
  localparam logic [1:0] LCC_RS_EXTR = 2'h1;
  localparam logic [1:0] LCC_RS_DCO = 2'h2;
  localparam logic [1:0] LCC_RS_UNDEF = 2'h3;
  localparam logic [1:0] LCC_RD_EXT_REF = 2'h3;
  // los figures
  localparam int LCC_LOS_UNIT = 16;
  localparam int LCC_LOS_MAX_ZEROS_C1 = 15;
  localparam logic [1:0] LCC_COND_ZEROS15 = 2'h1;
  localparam logic [8:0] LCC_BUF_BASE_BITS = 9'h100;
  localparam int LCC_CORNER_DIV = 10;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [7:0] dat;
  } lcc_wb_req_s;
  typedef struct packed {
    logic [1:0] rx_src_sel;
    logic osc_use_sync;
    logic osc_low_corner;
    logic osc_master;
    logic osc_center;
    logic tx_loop_timed;
    logic buf_in_tx;
    logic buf_en;
    logic [8:0] buf_depth_bits;
  } lcc_clk_ctl_s;
endpackage

// >>> design/lcc_channel.sv
module lcc_channel
  import lcc_pkg::*;
#(
  parameter int CHAN_COUNT = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // channel select: which of the four windows this instance answers
  input wire logic [1:0] chan_id_i,
  // recovered receive clock and line pulse indication from the slicer
  input wire logic rx_rec_clk_i,
  input wire logic line_pulse_i,
  input wire logic line_rx_data_i,
  // clock sources to pick from (sampled as levels)
  input wire logic pll_clk_i,
  input wire logic dco_clk_i,
  input wire logic [1:0] rx_data_output_sel_i,
  input wire logic tx_clock_missing_status_i,
  input wire logic sync_tied_i,
  input wire logic auto_remote_loop_i,
  input wire logic framer_tx_data_in_i,
  input wire logic tristate_pin_i,
  input wire logic tx_short_i,
  output logic rx_clk_o,
  output logic framer_rx_data_out_o,
  output logic line_tx_data_o,
  output logic line_tx_oe_o,
  output logic send_alarm_indication_o,
  output logic loss_of_signal_o,
  output logic tx_monitor_frozen_o,
  output logic [4:0] sub_pulse_level_o,
  output logic [1:0] sub_pulse_idx_o,
  output lcc_clk_ctl_s clk_ctl_o
);
  typedef struct packed {
    logic [7:0] clock_mode;
    logic [7:0] loop_control;
    logic [7:0] pulse_mask_0;
    logic [7:0] pulse_mask_1;
    logic [7:0] pulse_mask_2;
    logic [7:0] los_detect_count;
    logic [7:0] los_recovery_count;
    logic [7:0] loop_code_control;
    logic [7:0] los_config;
    logic ack;
    logic [7:0] rdat;
    logic err;
    logic [2:0] rclk_sync;
    logic [2:0] pulse_sync;
    logic [2:0] pll_sync;
    logic [2:0] dco_sync;
    logic [2:0] data_sync;
    logic rclk_prev;
    logic [12:0] zero_cnt;
    logic [12:0] win_cnt;
    logic [8:0] pulse_cnt;
    logic [4:0] run_zeros;
    logic run_fail;
    logic in_interval;
    logic loss_of_signal;
    logic monitor_short;
    logic [1:0] sub_idx;
    logic rx_clk;
    logic rx_data;
  } lcc_state_s;

  lcc_state_s q, d;

  // depth halves for each size code step
  function automatic logic [8:0] buf_depth(input logic [1:0] code);
    buf_depth = LCC_BUF_BASE_BITS >> code;
  endfunction

  // picks a 5-bit level out of the three mask registers
  function automatic logic [4:0] level_of(input logic [1:0] idx, input logic [23:0] m);
    logic [19:0] all;
    all = m[19:0];
    level_of = all[5*idx +: 5];
  endfunction

  logic [4:0] offs;
  logic hit;
  logic wr;
  logic rd_edge;
  logic pulse_seen;
  // 13 bits: the longest window, 16 * 256, does not fit in 12
  logic [12:0] detect_len;
  logic rx_buf_path;
  logic tristate;
  logic [7:0] rd_mux;

  // address decode; each channel owns one 0x20 window
  assign offs = wb_adr_i[4:0];
  assign hit = wb_adr_i[6:5] == chan_id_i;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && hit && !q.ack && wb_sel_i;

  // synchronised link signals; the third stage confirms the second
  assign rd_edge = q.rclk_sync[1] && q.rclk_sync[2] && !q.rclk_prev;
  assign pulse_seen = q.pulse_sync[1] && q.pulse_sync[2];
  assign detect_len = 13'(LCC_LOS_UNIT) * (13'(q.los_detect_count) + 13'h0001);
  assign rx_buf_path = q.loop_control[LCC_LC_EN] && !q.loop_control[LCC_LC_POS]
                       && (rx_data_output_sel_i != LCC_RD_EXT_REF);
  assign tristate = q.pulse_mask_2[LCC_PM_XLT] || tristate_pin_i;

  // register read mux, unmapped offsets read zero
  always_comb begin
    case (offs)
      LCC_OFS_CLOCK_MODE: rd_mux = q.clock_mode;
      LCC_OFS_LOOP_CTRL: rd_mux = q.loop_control;
      LCC_OFS_PULSE_MASK_0: rd_mux = q.pulse_mask_0;
      LCC_OFS_PULSE_MASK_1: rd_mux = q.pulse_mask_1;
      LCC_OFS_PULSE_MASK_2: rd_mux = q.pulse_mask_2;
      LCC_OFS_LOS_DETECT: rd_mux = q.los_detect_count;
      LCC_OFS_LOS_RECOVERY: rd_mux = q.los_recovery_count;
      LCC_OFS_LOOP_CODE: rd_mux = q.loop_code_control;
      LCC_OFS_LOS_CONFIG: rd_mux = q.los_config;
      LCC_OFS_STATUS: rd_mux = {6'h00, q.monitor_short, q.loss_of_signal};
      default: rd_mux = 8'h00;
    endcase
  end

  // next-state logic for the whole channel
  always_comb begin
    d = q;
    // bus: one wait state, ack drops the cycle after
    d.ack = wb_cyc_i && wb_stb_i && hit && !q.ack;
    d.err = 1'b0;
    d.rdat = rd_mux;
    if (wr) begin
      case (offs)
        LCC_OFS_CLOCK_MODE: d.clock_mode = wb_dat_i;
        LCC_OFS_LOOP_CTRL: d.loop_control = wb_dat_i;
        LCC_OFS_PULSE_MASK_0: d.pulse_mask_0 = wb_dat_i;
        LCC_OFS_PULSE_MASK_1: d.pulse_mask_1 = wb_dat_i;
        LCC_OFS_PULSE_MASK_2: d.pulse_mask_2 = wb_dat_i;
        LCC_OFS_LOS_DETECT: d.los_detect_count = wb_dat_i;
        LCC_OFS_LOS_RECOVERY: d.los_recovery_count = wb_dat_i;
        LCC_OFS_LOOP_CODE: d.loop_code_control = wb_dat_i;
        LCC_OFS_LOS_CONFIG: d.los_config = wb_dat_i;
        default: d.err = 1'b0;
      endcase
    end
    // three-stage samplers for the line inputs and the pll and dco reference clocks
    d.rclk_sync = {q.rclk_sync[1:0], rx_rec_clk_i};
    d.pulse_sync = {q.pulse_sync[1:0], line_pulse_i};
    d.pll_sync = {q.pll_sync[1:0], pll_clk_i};
    d.dco_sync = {q.dco_sync[1:0], dco_clk_i};
    d.data_sync = {q.data_sync[1:0], line_rx_data_i};
    if (q.rclk_sync[1] == q.rclk_sync[2]) begin
      d.rclk_prev = q.rclk_sync[2];
    end
    // loss of signal detection and recovery, one step per rx clock edge
    if (rd_edge) begin
      if (pulse_seen) begin
        d.zero_cnt = 13'h0000;
        d.run_zeros = 5'h00;
      end else begin
        if (q.zero_cnt != 13'h1FFF) begin
          d.zero_cnt = q.zero_cnt + 13'h0001;
        end
        if (q.run_zeros != 5'h1F) begin
          d.run_zeros = q.run_zeros + 5'h01;
        end
      end
      if (!q.loss_of_signal) begin
        if (!pulse_seen && (q.zero_cnt + 13'h0001 >= detect_len)) begin
          d.loss_of_signal = 1'b1;
          d.in_interval = 1'b0;
        end
      end else if (!q.in_interval) begin
        if (pulse_seen) begin
          d.in_interval = 1'b1;
          d.win_cnt = 13'h0001;
          d.pulse_cnt = 9'h001;
          d.run_fail = 1'b0;
        end
      end else begin
        d.win_cnt = q.win_cnt + 13'h0001;
        if (pulse_seen) begin
          d.pulse_cnt = q.pulse_cnt + 9'h001;
        end
        if (q.los_config[LCC_LS_COND_LSB +: 2] == LCC_COND_ZEROS15 && !pulse_seen
            && q.run_zeros >= 5'(LCC_LOS_MAX_ZEROS_C1)) begin
          d.run_fail = 1'b1;
        end
        if (d.pulse_cnt >= 9'(q.los_recovery_count) + 9'h001 && !d.run_fail) begin
          d.loss_of_signal = 1'b0;
          d.in_interval = 1'b0;
          d.zero_cnt = 13'h0000;
        end else if (q.win_cnt + 13'h0001 >= detect_len) begin
          d.in_interval = 1'b0;
        end
      end
      // sub-pulse levels stepped first to fourth
      d.sub_idx = q.sub_idx + 2'h1;
    end
    // short monitor; frozen while tristated
    if (!tristate) begin
      d.monitor_short = tx_short_i;
    end
    // receive clock output source select
    case (q.clock_mode[LCC_CM_RSRC_LSB +: 2])
      LCC_RS_PLL: d.rx_clk = rx_buf_path ? q.dco_sync[2] : q.pll_sync[2];
      LCC_RS_EXTR: d.rx_clk = q.loss_of_signal ? 1'b1 : q.rclk_sync[2];
      LCC_RS_DCO: d.rx_clk = q.dco_sync[2];
      default: d.rx_clk = 1'b0;
    endcase
    // receive data path with loopbacks and clearing
    if (q.loop_control[LCC_LC_LL] || q.loop_control[LCC_LC_DLB]) begin
      d.rx_data = framer_tx_data_in_i;
    end else if (q.loss_of_signal && q.loop_control[LCC_LC_CLR]) begin
      d.rx_data = 1'b0;
    end else begin
      d.rx_data = q.data_sync[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.clock_mode <= LCC_RST_CLOCK_MODE;
      q.loop_control <= LCC_RST_LOOP_CTRL;
      q.pulse_mask_0 <= LCC_RST_PULSE_MASK_0;
      q.pulse_mask_1 <= LCC_RST_PULSE_MASK_1;
      q.pulse_mask_2 <= LCC_RST_PULSE_MASK_2;
      q.los_detect_count <= LCC_RST_LOS_DETECT;
      q.los_recovery_count <= LCC_RST_LOS_RECOVERY;
      q.loop_code_control <= LCC_RST_LOOP_CODE;
      q.los_config <= LCC_RST_LOS_CONFIG;
    end else begin
      q <= d;
    end
  end

  // outputs
  logic remote_loop;
  assign remote_loop = q.loop_control[LCC_LC_RL] || auto_remote_loop_i;
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign wb_err_o = q.err;
  assign rx_clk_o = q.rx_clk;
  assign framer_rx_data_out_o = q.rx_data;
  assign line_tx_data_o = remote_loop ? q.data_sync[2] : framer_tx_data_in_i;
  assign line_tx_oe_o = !tristate
                        && !(q.monitor_short && !q.pulse_mask_2[LCC_PM_DISABLE_AUTO_TRISTATE]);
  assign send_alarm_indication_o = q.los_config[LCC_LS_AIS]
                                   && (q.loop_control[LCC_LC_LL] || q.loop_control[LCC_LC_DLB]);
  assign loss_of_signal_o = q.loss_of_signal;
  assign tx_monitor_frozen_o = tristate;
  assign sub_pulse_idx_o = q.sub_idx;
  assign sub_pulse_level_o = level_of(q.sub_idx,
    {q.pulse_mask_2, q.pulse_mask_1, q.pulse_mask_0});

  // oscillator and clock control word for the analog side
  always_comb begin
    clk_ctl_o.rx_src_sel = q.clock_mode[LCC_CM_RSRC_LSB +: 2];
    clk_ctl_o.osc_master = q.clock_mode[LCC_CM_MAS];
    clk_ctl_o.osc_center = q.clock_mode[LCC_CM_MAS] && sync_tied_i;
    clk_ctl_o.osc_use_sync = q.clock_mode[LCC_CM_MAS] || (!q.clock_mode[LCC_CM_DCS]
      && (q.loss_of_signal || tx_clock_missing_status_i));
    clk_ctl_o.osc_low_corner = q.clock_mode[LCC_CM_SCF];
    clk_ctl_o.tx_loop_timed = q.clock_mode[LCC_CM_ELT];
    clk_ctl_o.buf_in_tx = q.loop_control[LCC_LC_POS];
    clk_ctl_o.buf_en = q.loop_control[LCC_LC_EN] && !(q.clock_mode[LCC_CM_MAS] && sync_tied_i);
    clk_ctl_o.buf_depth_bits = buf_depth(q.loop_control[LCC_LC_BS_LSB +: 2]);
  end

  // assertions
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_rs01_high_los: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.loss_of_signal && q.clock_mode[5:4] == LCC_RS_EXTR) |=> rx_clk_o) else $error("rclk not high");
  a_clear_on_los: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.loss_of_signal && q.loop_control[LCC_LC_CLR] && !q.loop_control[LCC_LC_LL]
     && !q.loop_control[LCC_LC_DLB]) |=> !framer_rx_data_out_o) else $error("data not cleared");
  a_short_tristate: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.monitor_short && !q.pulse_mask_2[LCC_PM_DISABLE_AUTO_TRISTATE]) |-> !line_tx_oe_o) else $error("short driven");
  a_pin_tristate: assert property (@(posedge clk_i) disable iff (rst_i)
    tristate_pin_i |-> !line_tx_oe_o && tx_monitor_frozen_o) else $error("pin ignored");
  a_zero_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_edge && pulse_seen) |=> q.zero_cnt == 13'h0000) else $error("zero count kept");
  a_los_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.zero_cnt >= detect_len) |-> q.loss_of_signal || $past(q.loss_of_signal)) else $error("los missed");
  a_buf_depth: assert property (@(posedge clk_i) disable iff (rst_i)
    clk_ctl_o.buf_depth_bits == (9'h100 >> q.loop_control[1:0])) else $error("bad depth");
  a_switch_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.loss_of_signal && !q.clock_mode[LCC_CM_DCS]) |-> clk_ctl_o.osc_use_sync) else $error("no switch");
endmodule

// >>> sim/lcc_line_model.sv
// line side: recovered clock plus one mark per bit while active
module lcc_line_model (
  input wire logic active_i,
  output logic rec_clk_o,
  output logic pulse_o,
  output logic data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rec_clk_o = 1'b0;
    pulse_o = 1'b0;
    data_o = 1'b0;
  end

  // recovered clock runs on from the line pll, 80 ns period
  always #40 rec_clk_o = ~rec_clk_o;

  // launch on the falling edge so the rising edge sees settled data
  always @(negedge rec_clk_o) begin
    pulse_o <= active_i;
    data_o <= active_i; // a silent line is a space, never a held mark
  end
endmodule

// >>> sim/testbench.sv
module testbench;
  import lcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] OFS [8] = '{LCC_OFS_CLOCK_MODE, LCC_OFS_LOOP_CTRL,
    LCC_OFS_PULSE_MASK_0, LCC_OFS_PULSE_MASK_1, LCC_OFS_PULSE_MASK_2,
    LCC_OFS_LOS_DETECT, LCC_OFS_LOS_RECOVERY, LCC_OFS_LOOP_CODE};
  localparam logic [7:0] RST [8] = '{LCC_RST_CLOCK_MODE, LCC_RST_LOOP_CTRL,
    LCC_RST_PULSE_MASK_0, LCC_RST_PULSE_MASK_1, LCC_RST_PULSE_MASK_2,
    LCC_RST_LOS_DETECT, LCC_RST_LOS_RECOVERY, LCC_RST_LOOP_CODE};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_ack_o, wb_err_o, rec_clk, pulse, rxd;
  logic pll_clk, dco_clk, tcms, sync_tied, ftx, tri_pin, short, rx_clk, frx, ltx, loe;
  logic ais, loss_of_signal, frz, active;
  logic [7:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [7:0] exp_q [$];
  logic [7:0] v [8];
  logic [1:0] chan, idx;
  logic [4:0] lvl;
  lcc_clk_ctl_s ctl;
  int err_count, comparisons, cyc_cnt, n;

  always #5 clk_i = ~clk_i;

  lcc_line_model LINE (.active_i(active), .rec_clk_o(rec_clk), .pulse_o(pulse), .data_o(rxd));

  lcc_channel DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .chan_id_i(chan),
    .rx_rec_clk_i(rec_clk), .line_pulse_i(pulse), .line_rx_data_i(rxd),
    .pll_clk_i(pll_clk), .dco_clk_i(dco_clk), .rx_data_output_sel_i(2'h0),
    .tx_clock_missing_status_i(tcms), .sync_tied_i(sync_tied), .auto_remote_loop_i(1'b0),
    .framer_tx_data_in_i(ftx), .tristate_pin_i(tri_pin), .tx_short_i(short),
    .rx_clk_o(rx_clk), .framer_rx_data_out_o(frx), .line_tx_data_o(ltx),
    .line_tx_oe_o(loe), .send_alarm_indication_o(ais), .loss_of_signal_o(loss_of_signal),
    .tx_monitor_frozen_o(frz), .sub_pulse_level_o(lvl), .sub_pulse_idx_o(idx),
    .clk_ctl_o(ctl));

  task automatic conclude();
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic fail(input string m);
    err_count++;
    $display("mismatch %0t %s", $time, m);
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
    comparisons++;
    if (got !== exp) fail(m);
  endtask

  // one classic cycle; request held until ack is sampled, then released
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                     input logic s, input logic acked);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 16);
    chk(k < 16, acked, "ack presence");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 1'b1, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 8'h00, 1'b1, 1'b1);
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  // counts rising edges of the selected receive clock over a fixed span
  task automatic rises(output int c);
    logic p;
    c = 0;
    p = rx_clk;
    repeat (42) begin
      @(posedge clk_i);
      if (rx_clk === 1'b1 && p === 1'b0) c++;
      p = rx_clk;
    end
  endtask

  // read data is judged where the ack shows, oldest note first
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1) chk(wb_err_o, 1'b0, "error flag");
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) fail("read without note");
      else chk(wb_dat_o, exp_q.pop_front(), "read data");
    end
  end

  // free running reference clocks at unrelated rates, plus the hang guard
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt % 3 == 0) dco_clk <= ~dco_clk;
    if (cyc_cnt % 7 == 0) pll_clk <= ~pll_clk;
    if (cyc_cnt == 20000) begin
      fail("timeout");
      conclude();
    end
  end

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, tcms, sync_tied, ftx, tri_pin, short} = '0;
    {pll_clk, dco_clk, wb_adr_i, wb_dat_i, err_count, comparisons, cyc_cnt} = '0;
    active = 1'b1;
    chan = 2'h2;
    void'($urandom(32'h6543));
    tick(10);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd({3'h2, OFS[i]}, RST[i]);
    bus(8'h08, 1'b0, 8'h00, 1'b1, 1'b0);
    rd(8'h5F, 8'h00);
    // random readback; a write with sel low must leave the value alone
    for (int i = 1; i < 7; i++) begin
      v[i] = $urandom() & ((i == 4) ? 8'h7F : 8'hFF);
      wr({3'h2, OFS[i]}, v[i]);
      bus({3'h2, OFS[i]}, 1'b1, ~v[i], 1'b0, 1'b1);
      rd({3'h2, OFS[i]}, v[i]);
    end
    repeat (80) begin
      @(posedge clk_i);
      case (idx)
        2'h0: chk(lvl, v[2][4:0], "level 1");
        2'h1: chk(lvl, {v[3][1:0], v[2][7:5]}, "level 2");
        2'h2: chk(lvl, v[3][6:2], "level 3");
        default: chk(lvl, {v[4][3:0], v[3][7]}, "level 4");
      endcase
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h48, {i[0], i[1], 4'h0, i[1:0]});
      tick(2);
      chk(ctl.buf_depth_bits, 9'h100 >> i, "depth");
      chk({ctl.buf_in_tx, ctl.buf_en}, {i[0], i[1]}, "position");
    end
    for (int i = 0; i < 16; i++) begin
      wr(8'h4B, {1'b0, i[3], i[0], 5'h00});
      tri_pin <= i[2];
      short <= i[1];
      tick(3);
      chk(loe, !(i[3] | i[2] | (i[1] & !i[0])), "line enable");
      chk(frz, i[3] | i[2], "monitor freeze");
    end
    wr(8'h48, 8'h20);
    tick(4);
    chk(ltx, 1'b1, "remote loop");
    wr(8'h48, 8'h00);
    tick(4);
    chk(ltx, 1'b0, "framer to line");
    wr(8'h54, 8'h0C);
    wr(8'h48, 8'h08);
    tick(4);
    chk(frx, 1'b0, "digital loop");
    chk(ais, 1'b1, "alarm indication");
    wr(8'h54, 8'h00);
    wr(8'h48, 8'h10);
    ftx <= 1'b1;
    tick(4);
    chk(frx, 1'b1, "local loop");
    chk(ais, 1'b0, "no alarm indication");
    wr(8'h48, 8'h04);
    wr(8'h4C, 8'h00);
    wr(8'h4D, 8'h02);
    wr(8'h47, 8'h10);
    active <= 1'b0;
    tick(112);
    chk(loss_of_signal, 1'b0, "early alarm");
    for (n = 0; n < 60 && loss_of_signal !== 1'b1; n++) tick(1);
    chk(loss_of_signal, 1'b1, "alarm");
    chk(ctl.osc_use_sync, 1'b1, "switch to sync");
    repeat (20) begin
      @(posedge clk_i);
      chk(rx_clk, 1'b1, "clock held high");
      chk(frx, 1'b0, "data cleared");
    end
    wr(8'h47, 8'h18);
    tick(2);
    chk(ctl.osc_use_sync, 1'b0, "switch disabled");
    active <= 1'b1;
    tick(10);
    chk(loss_of_signal, 1'b1, "early recovery");
    for (n = 0; n < 80 && loss_of_signal !== 1'b0; n++) tick(1);
    chk(loss_of_signal, 1'b0, "recovery");
    wr(8'h47, 8'h00);
    tcms <= 1'b1;
    tick(3);
    chk(ctl.osc_use_sync, 1'b1, "tx clock missing");
    for (int i = 0; i < 3; i++) begin
      wr(8'h47, (i == 0) ? 8'h20 : 8'h00);
      wr(8'h48, (i == 2) ? 8'h40 : 8'h00);
      tick(4);
      rises(n);
      chk(n > ((i == 1) ? 1 : 5) && n < ((i == 1) ? 5 : 9), 1'b1, "clock source");
    end
    wr(8'h47, 8'h07);
    sync_tied <= 1'b1;
    tick(3);
    chk({ctl.osc_master, ctl.osc_center}, 2'h3, "master");
    chk(ctl.osc_low_corner, 1'b1, "corner");
    chk(ctl.tx_loop_timed, 1'b1, "loop timed");
    chan <= 2'h3;
    tick(1);
    rd(8'h6C, 8'h00);
    bus(8'h4C, 1'b0, 8'h00, 1'b1, 1'b0);
    tick(4);
    chk(exp_q.size(), 9'h000, "notes left");
    conclude();
  end
endmodule
